// ===== src/tas_pkg.sv
package tas_pkg;

  localparam int unsigned HDR_BYTES   = 5;
  localparam int unsigned INFO_BYTES  = 48;
  localparam int unsigned CELL_BYTES  = HDR_BYTES + INFO_BYTES;
  localparam int unsigned PFX_BYTES   = 4;
  localparam int unsigned DATA_BYTES  = 184;
  localparam int unsigned PKT_BYTES   = PFX_BYTES + DATA_BYTES;
  localparam int unsigned MAX_AAL     = 4;

  localparam logic [5:0] BIDX_HEC     = 6'h04;
  localparam logic [5:0] BIDX_AAL     = 6'h05;
  localparam logic [5:0] BIDX_LAST    = 6'h34;
  localparam logic [7:0] PIDX_LAST    = 8'hbb;
  localparam logic [7:0] PIDX_PFX1    = 8'h01;
  localparam logic [7:0] PIDX_PFX3    = 8'h03;
  localparam logic [7:0] PIDX_PFXEND  = 8'h04;
  localparam logic [5:0] AAL_NONE     = 6'h00;
  localparam logic [5:0] AAL_ONE      = 6'h01;
  localparam logic [5:0] AAL_TWO      = 6'h02;
  localparam logic [3:0] SAAL_TAG     = 4'h0;

  localparam logic [7:0] HEC_POLY     = 8'h07;
  localparam logic [7:0] HEC_COSET    = 8'h55;

  typedef enum logic [1:0] {
    TAS_MODE_NULL   = 2'b00,
    TAS_MODE_SINGLE = 2'b01,
    TAS_MODE_DUAL   = 2'b10
  } tas_mode_t;

  typedef struct packed {
    logic [3:0]  gfc;
    logic [7:0]  vpi;
    logic [15:0] vci;
    logic [2:0]  pt;
    logic        clp;
  } tas_hdr_t;

  typedef struct packed {
    logic [7:0] data;
    logic       sop;
  } tas_byte_t;

  typedef struct packed {
    tas_byte_t  hold;
    logic       hold_v;
    logic       in_rdy;
    tas_byte_t  outb;
    logic       out_v;
    logic [5:0] bidx;
    logic [7:0] pidx;
    logic [1:0] seq;
    tas_mode_t  mode;
    logic [7:0] pfx1;
    logic [7:0] pfx3;
  } tas_state_t;

endpackage

// ===== src/tas_hec.sv
`timescale 1ns/1ps
// crc-8 over four header bytes, msb first, coset added
module tas_hec
  import tas_pkg::*;
(
  input  wire logic [31:0] hdr_i,
  output logic      [7:0]  hec_o
);

  logic [7:0] crc;

  always_comb begin
    crc = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      if (crc[7] ^ hdr_i[i]) begin
        crc = {crc[6:0], 1'b0} ^ HEC_POLY;
      end else begin
        crc = {crc[6:0], 1'b0};
      end
    end
    hec_o = crc ^ HEC_COSET;
  end

endmodule // tas_hec

// ===== src/tas_segmenter.sv
`timescale 1ns/1ps
// Functional notes
// - each cell is five header bytes then forty-eight information bytes
// - header carries a four-bit generic flow control field
// - header carries an eight-bit virtual path identifier
// - header carries a sixteen-bit virtual circuit identifier
// - header carries a three-bit payload type field
// - header carries a one-bit cell loss priority flag
// - header ends with an eight-bit header error control byte
// - no more than four information bytes used for adaptation bytes
// - input packet is four prefix bytes plus 184 data bytes
// - null method: stream cut into consecutive 48-byte information fields
// - null method: five-byte header added, no adaptation byte
// - null method: packet bytes run across cell boundaries continuously
// - single method: packet cut in 47-byte segments from first prefix byte
// - single method: four segments per packet, packets start cells
// - single method: one adaptation byte plus header gives 53 bytes
// - single adaptation byte carries segment position in packet
// - dual method: prefix dropped, 184 bytes cut into four 46-byte pieces
// - dual method: two adaptation bytes plus header per piece
// - dual method: unrebuildable prefix fields go into adaptation bytes
module tas_segmenter
  import tas_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire tas_mode_t  mode_i,
  input  wire tas_hdr_t   hdr_i,
  input  wire tas_byte_t  in_i,
  input  wire logic       in_valid_i,
  output logic            in_ready_o,
  output tas_byte_t       out_o,
  output logic            out_valid_o,
  input  wire logic       out_ready_i
);

  tas_state_t s;
  tas_state_t next_s;
  logic [7:0] hec;
  logic [5:0] aal_len;
  logic [1:0] cseq;
  logic       pkt_start;
  tas_mode_t  em;
  logic       take;
  logic       emit;

  tas_hec u_hec (
    .hdr_i (hdr_i),
    .hec_o (hec)
  );

  always_comb begin
    next_s    = s;
    take      = 1'b0;
    emit      = 1'b0;
    pkt_start = (s.bidx == 6'h00) && (s.pidx == 8'h00);
    // mode taken at packet start only
    em        = pkt_start ? mode_i : s.mode;
    cseq      = pkt_start ? 2'b00 : s.seq;
    unique case (em)
      TAS_MODE_SINGLE: aal_len = AAL_ONE;
      TAS_MODE_DUAL:   aal_len = AAL_TWO;
      default:         aal_len = AAL_NONE;
    endcase
    if (s.out_v && out_ready_i) begin
      next_s.out_v = 1'b0;
    end
    if (!s.out_v || out_ready_i) begin
      if (pkt_start) begin
        next_s.mode = em;
        next_s.seq  = 2'b00;
      end
      if (s.hold_v && (s.pidx == 8'h00) && !s.hold.sop) begin
        // segmenting starts at first prefix byte
        // hunt for packet start
        take = 1'b1;
      end else if ((em == TAS_MODE_DUAL) && (s.pidx < PIDX_PFXEND) && (s.bidx == 6'h00)) begin
        if (s.hold_v) begin
          take        = 1'b1;
          next_s.pidx = s.pidx + 8'h01;
          if (s.pidx == PIDX_PFX1) begin
            next_s.pfx1 = s.hold.data;
          end
          if (s.pidx == PIDX_PFX3) begin
            next_s.pfx3 = s.hold.data;
          end
        end
      end else begin
        emit = 1'b1;
        unique case (s.bidx)
          6'h00: next_s.outb.data = {hdr_i.gfc, hdr_i.vpi[7:4]};
          6'h01: next_s.outb.data = {hdr_i.vpi[3:0], hdr_i.vci[15:12]};
          6'h02: next_s.outb.data = hdr_i.vci[11:4];
          6'h03: next_s.outb.data = {hdr_i.vci[3:0], hdr_i.pt, hdr_i.clp};
          BIDX_HEC: next_s.outb.data = hec;
          default: begin
            if (s.bidx < BIDX_AAL + aal_len) begin
              if (em == TAS_MODE_SINGLE) begin
                next_s.outb.data = {SAAL_TAG, 2'b00, cseq};
              end else if (s.bidx == BIDX_AAL) begin
                next_s.outb.data = {s.pfx1[7:5], 3'b000, cseq};
              end else begin
                next_s.outb.data = s.pfx3;
              end
            end else if (s.hold_v) begin
              next_s.outb.data = s.hold.data;
              take             = 1'b1;
              next_s.pidx      = (s.pidx == PIDX_LAST) ? 8'h00 : s.pidx + 8'h01;
            end else begin
              emit = 1'b0;
            end
          end
        endcase
        if (emit) begin
          next_s.out_v    = 1'b1;
          next_s.outb.sop = (s.bidx == 6'h00);
          if (s.bidx == BIDX_LAST) begin
            next_s.bidx = 6'h00;
            next_s.seq  = cseq + 2'b01;
          end else begin
            next_s.bidx = s.bidx + 6'h01;
            next_s.seq  = cseq;
          end
        end
      end
    end
    if (take) begin
      next_s.hold_v = 1'b0;
    end
    if (in_valid_i && s.in_rdy) begin
      next_s.hold   = in_i;
      next_s.hold_v = 1'b1;
    end
    next_s.in_rdy = !next_s.hold_v;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s        <= '0;
      s.in_rdy <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign in_ready_o  = s.in_rdy;
  assign out_o       = s.outb;
  assign out_valid_o = s.out_v;

  // helper: position of each delivered byte within its cell
  logic       fire;
  logic [5:0] ocnt;
  logic [5:0] opos;
  logic       seen_sop;
  logic [7:0] hec_q;
  tas_hdr_t   hdr_q;
  tas_mode_t  mode_q;
  logic       pay_q;

  assign fire = s.out_v && out_ready_i;
  assign opos = s.outb.sop ? 6'h00 : ocnt;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ocnt     <= 6'h00;
      seen_sop <= 1'b0;
      hec_q    <= 8'h00;
      hdr_q    <= '0;
      mode_q   <= TAS_MODE_NULL;
      pay_q    <= 1'b0;
    end else begin
      hec_q  <= hec;
      hdr_q  <= hdr_i;
      mode_q <= s.mode;
      if (emit) begin
        pay_q <= take;
      end
      if (fire) begin
        ocnt <= opos + 6'h01;
        if (s.outb.sop) begin
          seen_sop <= 1'b1;
        end
      end
    end
  end

  chk_cell_length: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fire && s.outb.sop && seen_sop |-> ocnt == 6'(CELL_BYTES))
    else $error("cell did not hold 53 bytes");

  chk_hdr_gfc: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fire && s.outb.sop |-> s.outb.data[7:4] == hdr_q.gfc)
    else $error("generic flow control field wrong");

  chk_hdr_vpi: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fire && seen_sop && opos == 6'h01 |-> s.outb.data[7:4] == hdr_q.vpi[3:0])
    else $error("path identifier low nibble wrong");

  chk_hdr_vci: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fire && seen_sop && opos == 6'h02 |-> s.outb.data == hdr_q.vci[11:4])
    else $error("circuit identifier middle byte wrong");

  chk_hdr_ptclp: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fire && seen_sop && opos == 6'h03 |-> s.outb.data[3:0] == {hdr_q.pt, hdr_q.clp})
    else $error("payload type or loss priority wrong");

  chk_hec_byte: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fire && seen_sop && opos == BIDX_HEC && $stable(hdr_i) |-> s.outb.data == hec_q)
    else $error("header error control byte wrong");

  chk_single_pos: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fire && seen_sop && opos == BIDX_AAL && mode_q == TAS_MODE_SINGLE |-> s.outb.data[7:2] == 6'h00)
    else $error("single adaptation byte malformed");

  chk_input_held: assert property (@(posedge clk_i) disable iff (!nrst_i)
    in_valid_i && in_ready_o |=> !in_ready_o && $past(in_i) == s.hold)
    else $error("accepted input byte not held");

  chk_out_stable: assert property (@(posedge clk_i) disable iff (!nrst_i)
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_o))
    else $error("output byte changed while stalled");

  chk_hdr_clp: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fire && seen_sop && opos == 6'h03 |-> s.outb.data[0] == hdr_q.clp)
    else $error("cell loss priority bit wrong");

  chk_hdr_vpi_hi: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fire && s.outb.sop |-> s.outb.data[3:0] == hdr_q.vpi[7:4])
    else $error("path identifier high nibble wrong");

  chk_hdr_vci_hi: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fire && seen_sop && opos == 6'h01 |-> s.outb.data[3:0] == hdr_q.vci[15:12])
    else $error("circuit identifier high nibble wrong");

  chk_hdr_vci_lo: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fire && seen_sop && opos == 6'h03 |-> s.outb.data[7:4] == hdr_q.vci[3:0])
    else $error("circuit identifier low nibble wrong");

  chk_hdr_pt: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fire && seen_sop && opos == 6'h03 |-> s.outb.data[3:1] == hdr_q.pt)
    else $error("payload type field wrong");

  chk_aal_limit: assert property (@(posedge clk_i) disable iff (!nrst_i)
    aal_len <= 6'(MAX_AAL))
    else $error("too many adaptation bytes");

  chk_pidx_range: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s.pidx <= PIDX_LAST)
    else $error("packet byte index out of range");

  chk_hdr_nostream: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fire && seen_sop && opos < BIDX_AAL |-> !pay_q)
    else $error("stream byte inside cell header");

  // sop only on cell byte zero
  chk_sop_first: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fire && seen_sop && !s.outb.sop |-> ocnt != 6'h00 && ocnt < 6'(CELL_BYTES))
    else $error("cell byte position out of range");

  chk_pay_order: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fire && seen_sop && pay_q |-> opos >= BIDX_AAL)
    else $error("payload byte before end of header");

  // null cells carry no adaptation byte
  chk_null_payload: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fire && seen_sop && s.mode == TAS_MODE_NULL && opos >= BIDX_AAL |-> pay_q)
    else $error("null cell information byte not from stream");

  chk_single_aal: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fire && seen_sop && s.mode == TAS_MODE_SINGLE && opos >= BIDX_AAL |-> pay_q == (opos != BIDX_AAL))
    else $error("single cell layout wrong");

  chk_dual_aal: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fire && seen_sop && s.mode == TAS_MODE_DUAL && opos >= BIDX_AAL |-> pay_q == (opos > BIDX_AAL + 6'h01))
    else $error("dual cell layout wrong");

  chk_dual_prefix: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fire && seen_sop && s.mode == TAS_MODE_DUAL && opos == BIDX_AAL + 6'h01 |-> s.outb.data == s.pfx3)
    else $error("dual second adaptation byte wrong");

  chk_single_align: assert property (@(posedge clk_i) disable iff (!nrst_i)
    emit && s.bidx == 6'h00 && em == TAS_MODE_SINGLE |-> (s.pidx % 8'(INFO_BYTES - 32'd1)) == 8'h00)
    else $error("single cell not on segment bound");

  chk_four_seg: assert property (@(posedge clk_i) disable iff (!nrst_i)
    emit && s.bidx == BIDX_LAST && em == TAS_MODE_SINGLE |-> (cseq == 2'b11) == (s.pidx == PIDX_LAST))
    else $error("single packet not four cells");

  chk_dual_align: assert property (@(posedge clk_i) disable iff (!nrst_i)
    emit && s.bidx == 6'h00 && em == TAS_MODE_DUAL |-> 8'(s.pidx - PIDX_PFXEND) % 8'(INFO_BYTES - 32'd2) == 8'h00)
    else $error("dual cell not on piece bound");

  chk_dual_four: assert property (@(posedge clk_i) disable iff (!nrst_i)
    emit && s.bidx == BIDX_LAST && em == TAS_MODE_DUAL |-> (cseq == 2'b11) == (s.pidx == PIDX_LAST))
    else $error("dual packet not four cells");

  chk_mode_static: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !pkt_start |=> $stable(s.mode))
    else $error("mode changed inside a packet");

  cov_null_cell: cover property (@(posedge clk_i) disable iff (!nrst_i)
    fire && s.outb.sop && s.mode == TAS_MODE_NULL);
  cov_single_cell: cover property (@(posedge clk_i) disable iff (!nrst_i)
    fire && s.outb.sop && s.mode == TAS_MODE_SINGLE && s.seq == 2'b11);
  cov_dual_cell: cover property (@(posedge clk_i) disable iff (!nrst_i)
    fire && s.outb.sop && s.mode == TAS_MODE_DUAL);
  cov_stall: cover property (@(posedge clk_i) disable iff (!nrst_i)
    out_valid_o && !out_ready_i ##1 out_valid_o && out_ready_i);

endmodule // tas_segmenter

// ===== verification/tas_sink.sv
`timescale 1ns/1ps
module tas_sink
  import tas_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      nrst_i,
  input  wire logic      stall_i,
  input  wire tas_byte_t byte_i,
  input  wire logic      valid_i,
  output logic           ready_o
);
  tas_byte_t   cap [0:511];
  int unsigned cnt;
  logic [1:0]  ph;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 0;
      ph  <= 2'h0;
      ready_o <= 1'b1;
    end else begin
      if (valid_i && ready_o) begin
        cap[cnt] <= byte_i;
        cnt      <= cnt + 1;
      end
      ph      <= ph + 2'h1;
      ready_o <= #1 !(stall_i && ph != 2'h0);
    end
  end
endmodule // tas_sink

// ===== verification/transport_to_atm_cell_segmenter_bench.sv
`timescale 1ns/1ps
module transport_to_atm_cell_segmenter_bench
  import tas_pkg::*;
;
  logic      clk_i;
  logic      nrst_i;
  tas_mode_t mode;
  tas_hdr_t  hdr;
  tas_byte_t in_b;
  logic      in_valid;
  logic      in_ready;
  tas_byte_t out_b;
  logic      out_valid;
  logic      out_ready;
  logic      stall;
  int        mismatches;
  int        tests_run;

  tas_segmenter dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .mode_i(mode), .hdr_i(hdr), .in_i(in_b),
    .in_valid_i(in_valid), .in_ready_o(in_ready), .out_o(out_b), .out_valid_o(out_valid),
    .out_ready_i(out_ready));
  tas_sink sink_u (.clk_i(clk_i), .nrst_i(nrst_i), .stall_i(stall), .byte_i(out_b),
    .valid_i(out_valid), .ready_o(out_ready));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [7:0] pbyte(int k);
    return 8'(k * 3 + 1);
  endfunction

  function automatic logic [7:0] calc_hec(logic [31:0] h);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h07 : 8'h00);
    return c ^ 8'h55;
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic do_reset(tas_mode_t m, logic st);
    #1;
    nrst_i   = 1'b0;
    mode     = m;
    stall    = st;
    in_valid = 1'b0;
    in_b     = '0;
    repeat (10) @(posedge clk_i);
    tests_run++;
    if (out_valid !== 1'b0 || in_ready !== 1'b1) begin
      mismatches++;
      $display("[ERR] reset outputs exp 0/1 seen %b/%b", out_valid, in_ready);
    end
    #1 nrst_i = 1'b1;
  endtask

  task automatic send_pkt(int junk, int n);
    int   k;
    int   t;
    logic rdy;
    for (int i = 0; i < junk + n * 188; i++) begin
      k        = i - junk;
      in_b     = '{data: (k >= 0) ? pbyte(k) : 8'hee, sop: (k >= 0 && k % 188 == 0)};
      in_valid = 1'b1;
      t        = 0;
      rdy      = in_ready;
      while (rdy !== 1'b1) begin
        if (++t > 400) begin
          mismatches++;
          $display("[ERR] in_ready exp 1 seen %b", rdy);
          tally_and_finish();
        end
        @(posedge clk_i);
        #1 rdy = in_ready;
      end
      @(posedge clk_i);
      #1;
    end
    in_valid = 1'b0;
  endtask

  task automatic check_cells(tas_mode_t m, int n, string nm);
    int        t;
    int        na;
    int        k0;
    logic [7:0] e;
    logic [7:0] p1;
    tas_byte_t  s;
    t  = 0;
    na = (m == TAS_MODE_SINGLE) ? 1 : (m == TAS_MODE_DUAL) ? 2 : 0;
    p1 = pbyte(1);
    while (sink_u.cnt < n * 53) begin
      if (++t > 30000) begin
        mismatches++;
        $display("[ERR] %s cell bytes exp %0d seen %0d", nm, n * 53, sink_u.cnt);
        tally_and_finish();
      end
      @(posedge clk_i);
    end
    for (int c = 0; c < n; c++) begin
      k0 = (m == TAS_MODE_SINGLE) ? c * 47 : (m == TAS_MODE_DUAL) ? 4 + c * 46 : c * 48;
      for (int j = 0; j < 53; j++) begin
        if (j < 4) e = hdr[31 - 8 * j -: 8];
        else if (j == 4) e = calc_hec(hdr);
        else if (j == 5 && na == 1) e = {6'h00, 2'(c)};
        else if (j == 5 && na == 2) e = {p1[7:5], 3'b000, 2'(c)};
        else if (j == 6 && na == 2) e = pbyte(3);
        else e = pbyte(k0 + j - 5 - na);
        s = sink_u.cap[c * 53 + j];
        tests_run++;
        if (s !== {e, (j == 0)}) begin
          mismatches++;
          $display("[ERR] %s cell %0d byte %0d exp %h seen %h", nm, c, j, {e, (j == 0)}, s);
        end
      end
    end
    $display("test %s done", nm);
  endtask

  initial begin
    nrst_i   = 1'b0;
    mode     = TAS_MODE_NULL;
    hdr      = '{gfc: 4'ha, vpi: 8'h3c, vci: 16'hb2e1, pt: 3'h5, clp: 1'b1};
    in_b     = '0;
    in_valid = 1'b0;
    stall    = 1'b0;
    do_reset(TAS_MODE_NULL, 1'b0);
    send_pkt(0, 2);
    check_cells(TAS_MODE_NULL, 7, "null");
    do_reset(TAS_MODE_SINGLE, 1'b0);
    send_pkt(3, 1);
    check_cells(TAS_MODE_SINGLE, 4, "single");
    do_reset(TAS_MODE_DUAL, 1'b1);
    send_pkt(0, 1);
    check_cells(TAS_MODE_DUAL, 4, "dual");
    tally_and_finish();
  end
endmodule // transport_to_atm_cell_segmenter_bench
